// >>> hw/stop_len_ctrl.sv
// Overview of operation
// RULE1 - Six to eight bit characters: stop from 9/16 to two bits.
// RULE2 - Five bit characters get stop intervals from 17/16 to two bits.
// RULE3 - Code 0 gives 17 or 9 sixteenths; codes 7 and 15 give 16, 32. With five bit characters code 7 gives 24 here.
// RULE4 - Receiver samples only mid first stop bit, one bit after last bit.
// RULE5 - With external 1x clock only selection bit 3 counts: one or two bits.
// RULE6 - In modem mode the stop selection field has no effect.
// RULE7 - Line stays idle high for the whole stop interval before next start.
`timescale 1ns/1ps
module stop_len_ctrl
  import stop_len_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Mode settings
  input wire logic [3:0] stop_len_sel,
  input wire logic [1:0] char_len,
  input wire logic parity_en,
  input wire logic ext_1x_clk,
  input wire logic modem_mode,
  // Bit-rate ticks
  input wire logic tick16,
  input wire logic tick1x,
  // Transmitter side
  input wire logic tx_stop_start,
  output logic tx_stop_busy,
  output logic tx_stop_done,
  // Receiver side
  input wire logic rx_data_centre,
  input wire logic rx_parity_centre,
  input wire logic rxd,
  output logic rx_stop_wait,
  output logic rx_stop_ok,
  output logic rx_frame_err
);

  tx_state_t tx_state;
  rx_state_t rx_state;
  logic [CNT_W-1:0] next_len;
  logic [CNT_W-1:0] tx_len;
  logic [CNT_W-1:0] tx_cnt;
  logic [CNT_W-1:0] rx_cnt;
  logic tx_ext;
  logic tx_tick;
  logic tx_accept;
  logic tx_last;
  logic rx_begin;
  logic rx_last;

  // Stop interval in ticks for the character about to finish
  always_comb begin
    if (modem_mode) begin
      next_len = MODEM_STOP_TICKS; // RULE6
    end else if (ext_1x_clk) begin
      next_len = stop_len_sel[SEL_TOP_BIT] ? EXT_TWO_STOP
                                           : EXT_ONE_STOP; // RULE5
    end else if (char_len == CHAR_LEN_5) begin
      next_len = FIVE_BIT_BASE + {2'h0, stop_len_sel}; // RULE2
    end else if (!stop_len_sel[SEL_TOP_BIT]) begin
      next_len = WIDE_LOW_BASE + {2'h0, stop_len_sel}; // RULE1
    end else begin
      next_len = WIDE_HIGH_BASE + {2'h0, stop_len_sel}; // RULE3
    end
  end

  assign tx_tick = tx_ext ? tick1x : tick16;
  assign tx_accept = (tx_state == TX_IDLE) && tx_stop_start;
  assign tx_last = (tx_state == TX_STOP) && tx_tick &&
                   (tx_cnt + 6'h01 == tx_len);

  // Transmit stop timer; starts are ignored until the interval ends
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_state <= TX_IDLE;
      tx_cnt <= CNT_RESET;
      tx_len <= CNT_RESET;
      tx_ext <= 1'h0;
    end else begin
      unique case (tx_state)
        TX_IDLE: begin
          if (tx_stop_start) begin
            tx_state <= TX_STOP;
            tx_cnt <= CNT_RESET;
            tx_len <= next_len;
            tx_ext <= ext_1x_clk && !modem_mode;
          end
        end
        TX_STOP: begin
          if (tx_last) begin
            tx_state <= TX_IDLE; // RULE7
          end else if (tx_tick) begin
            tx_cnt <= tx_cnt + 6'h01;
          end
        end
      endcase
    end
  end

  // Transmit status flags
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_stop_busy <= 1'h0;
      tx_stop_done <= 1'h0;
    end else begin
      tx_stop_busy <= tx_accept || ((tx_state == TX_STOP) && !tx_last);
      tx_stop_done <= tx_last; // RULE7
    end
  end

  // Receive check starts at the centre of the last data or parity bit
  assign rx_begin = parity_en ? rx_parity_centre : rx_data_centre; // RULE4
  assign rx_last = (rx_state == RX_WAIT) && tick16 &&
                   (rx_cnt + 6'h01 == ONE_BIT_TICKS);

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_state <= RX_IDLE;
      rx_cnt <= CNT_RESET;
    end else begin
      unique case (rx_state)
        RX_IDLE: begin
          if (rx_begin) begin
            rx_state <= RX_WAIT;
            rx_cnt <= CNT_RESET;
          end
        end
        RX_WAIT: begin
          if (rx_last) begin
            rx_state <= RX_IDLE;
          end else if (tick16) begin
            rx_cnt <= rx_cnt + 6'h01;
          end
        end
      endcase
    end
  end

  // Single sample of the line, whatever stop length is programmed
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rx_stop_wait <= 1'h0;
      rx_stop_ok <= 1'h0;
      rx_frame_err <= 1'h0;
    end else begin
      rx_stop_wait <= ((rx_state == RX_IDLE) && rx_begin) ||
                      ((rx_state == RX_WAIT) && !rx_last);
      rx_stop_ok <= rx_last && rxd; // RULE4
      rx_frame_err <= rx_last && !rxd; // RULE4
    end
  end

  // Helper counters of ticks seen since each start
  logic [CNT_W-1:0] tx_seen;
  logic [CNT_W-1:0] rx_seen;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tx_seen <= CNT_RESET;
      rx_seen <= CNT_RESET;
    end else begin
      if (tx_accept) begin
        tx_seen <= CNT_RESET;
      end else if ((tx_state == TX_STOP) && tx_tick) begin
        tx_seen <= tx_seen + 6'h01;
      end
      if ((rx_state == RX_IDLE) && rx_begin) begin
        rx_seen <= CNT_RESET;
      end else if ((rx_state == RX_WAIT) && tick16) begin
        rx_seen <= rx_seen + 6'h01;
      end
    end
  end

  wide_range_a: assert property (@(posedge clk) disable iff (!nrst) // RULE1
    (tx_accept && !modem_mode && !ext_1x_clk && char_len != CHAR_LEN_5)
    |=> (tx_len >= 6'h09) && (tx_len <= 6'h20))
    else $error("wide character stop length out of range");

  five_range_a: assert property (@(posedge clk) disable iff (!nrst) // RULE2
    (tx_accept && !modem_mode && !ext_1x_clk && char_len == CHAR_LEN_5)
    |=> (tx_len >= 6'h11) && (tx_len <= 6'h20))
    else $error("five bit stop length out of range");

  code_points_a: assert property (@(posedge clk) disable iff (!nrst) // RULE3
    (tx_accept && !modem_mode && !ext_1x_clk) |=>
    ($past(stop_len_sel) != 4'h0 || tx_len ==
      (($past(char_len) == CHAR_LEN_5) ? 6'h11 : 6'h09)) &&
    ($past(stop_len_sel) != 4'h7 || $past(char_len) == CHAR_LEN_5 ||
      tx_len == 6'h10) &&
    ($past(stop_len_sel) != 4'hF || tx_len == 6'h20))
    else $error("stop code maps to wrong length");

  rx_centre_a: assert property (@(posedge clk) disable iff (!nrst) // RULE4
    (rx_stop_ok || rx_frame_err) |-> (rx_seen == 6'h10) &&
    (rx_stop_ok == $past(rxd)))
    else $error("receiver stop sample taken at wrong point");

  ext_clock_a: assert property (@(posedge clk) disable iff (!nrst) // RULE5
    (tx_accept && ext_1x_clk && !modem_mode) |=>
    tx_len == ($past(stop_len_sel[3]) ? 6'h02 : 6'h01))
    else $error("external clock stop count wrong");

  modem_fixed_a: assert property (@(posedge clk) disable iff (!nrst) // RULE6
    (tx_accept && modem_mode) |=> tx_len == 6'h10)
    else $error("modem mode stop length depends on field");

  stop_whole_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
    tx_stop_done |-> (tx_seen == tx_len) && !tx_stop_busy &&
    $past(tx_stop_busy))
    else $error("stop interval ended early or late");

  busy_hold_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
    (tx_stop_busy && !tx_stop_done) |-> (tx_state == TX_STOP) &&
    (tx_seen < tx_len))
    else $error("line released before stop interval ended");

  // A start that arrives while the interval runs must not reload it
  stop_held_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
    (tx_stop_busy && !tx_stop_done) |=> $stable(tx_len))
    else $error("stop length changed while interval runs");

  done_pulse_a: assert property (@(posedge clk) disable iff (!nrst) // RULE7
    tx_stop_done |=> !tx_stop_done)
    else $error("stop done flag held longer than one cycle");

  rx_result_a: assert property (@(posedge clk) disable iff (!nrst) // RULE4
    (rx_stop_ok || rx_frame_err) |-> !rx_stop_wait &&
    !(rx_stop_ok && rx_frame_err))
    else $error("receiver result flags inconsistent");

endmodule

// >>> hw/stop_len_pkg.sv
package stop_len_pkg;
  localparam int CNT_W = 6;
  // Stop interval in sixteenths of a bit is base plus selection code
  localparam logic [CNT_W-1:0] FIVE_BIT_BASE = 6'h11;
  localparam logic [CNT_W-1:0] WIDE_LOW_BASE = 6'h09;
  localparam logic [CNT_W-1:0] WIDE_HIGH_BASE = 6'h11;
  localparam logic [CNT_W-1:0] ONE_BIT_TICKS = 6'h10;
  localparam logic [CNT_W-1:0] EXT_ONE_STOP = 6'h01;
  localparam logic [CNT_W-1:0] EXT_TWO_STOP = 6'h02;
  localparam logic [CNT_W-1:0] MODEM_STOP_TICKS = 6'h10;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  localparam logic [1:0] CHAR_LEN_5 = 2'h0;
  localparam int SEL_TOP_BIT = 3;

  typedef enum logic {
    TX_IDLE = 1'b0,
    TX_STOP = 1'b1
  } tx_state_t;

  typedef enum logic {
    RX_IDLE = 1'b0,
    RX_WAIT = 1'b1
  } rx_state_t;
endpackage

// >>> test/serial_peer.sv
`timescale 1ns/1ps
module serial_peer (
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Level the remote end puts on the line
  input wire logic stop_bit,
  // Bit-rate ticks and line
  output logic tick16,
  output logic tick1x,
  output logic rxd
);
  logic [4:0] div;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) div <= 5'h00;
    else div <= div + 5'h01;
  end
  // Sixteenth ticks every second cycle, one bit is 32 cycles
  assign tick16 = div[0];
  assign tick1x = (div == 5'h1F);
  assign rxd = stop_bit;
endmodule

// >>> test/test_stop_len_ctrl.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("FAIL t=%0t %h %h", $time, a, b); end end
module test_stop_len_ctrl;
  import stop_len_pkg::*;
  logic clk = 0, nrst = 0, parity_en = 0, ext_1x_clk = 0, modem_mode = 0;
  logic [3:0] stop_len_sel = 4'h0;
  logic [1:0] char_len = 2'h1;
  logic tx_stop_start = 0, rx_data_centre = 0, rx_parity_centre = 0;
  logic stop_bit = 1, tick16, tick1x, rxd, tx_stop_busy, tx_stop_done;
  logic rx_stop_wait, rx_stop_ok, rx_frame_err;
  int errors = 0, n_checks = 0;
  serial_peer u_peer (.clk(clk), .nrst(nrst), .stop_bit(stop_bit),
    .tick16(tick16), .tick1x(tick1x), .rxd(rxd));
  stop_len_ctrl u_dut (.clk(clk), .nrst(nrst), .stop_len_sel(stop_len_sel),
    .char_len(char_len), .parity_en(parity_en), .ext_1x_clk(ext_1x_clk),
    .modem_mode(modem_mode), .tick16(tick16), .tick1x(tick1x),
    .tx_stop_start(tx_stop_start), .tx_stop_busy(tx_stop_busy),
    .tx_stop_done(tx_stop_done), .rx_data_centre(rx_data_centre),
    .rx_parity_centre(rx_parity_centre), .rxd(rxd),
    .rx_stop_wait(rx_stop_wait), .rx_stop_ok(rx_stop_ok),
    .rx_frame_err(rx_frame_err));
  initial begin
    forever #5 clk = ~clk;
  end
  task automatic stop_test();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // Count ticks while the stop interval runs; the line is held idle meanwhile
  task automatic tx_run(logic [3:0] s, logic [1:0] c, logic e, logic m,
      logic [5:0] exp);
    logic [5:0] n;
    n = 6'h00;
    @(negedge clk);
    {stop_len_sel, char_len, ext_1x_clk, modem_mode} = {s, c, e, m};
    tx_stop_start = 1'h1;
    @(negedge clk);
    // A second start while busy must be ignored
    for (int i = 0; i < 2000 && tx_stop_done !== 1'b1; i++) begin
      tx_stop_start = (i == 2) && (tx_stop_busy === 1'b1);
      if (tx_stop_busy === 1'b1 && ((e && !m) ? tick1x : tick16)) n++;
      @(negedge clk);
      if (i == 1999) begin errors++; stop_test(); end
    end
    tx_stop_start = 1'h0;
    `CHK(n, exp)
    `CHK(tx_stop_busy, 1'h0)
    @(negedge clk);
    `CHK({tx_stop_done, tx_stop_busy}, 2'h0)
  endtask
  // One centre pulse on the unused input first, which must not start a wait
  task automatic rx_run(logic p, logic b);
    logic [5:0] n;
    n = 6'h00;
    @(negedge clk);
    // Stop code differs per run; the receiver must not depend on it
    {parity_en, stop_bit, stop_len_sel} = {p, b, {4{p}}};
    {rx_data_centre, rx_parity_centre} = p ? 2'b10 : 2'b01;
    @(negedge clk);
    `CHK(rx_stop_wait, 1'b0)
    {rx_data_centre, rx_parity_centre} = p ? 2'b01 : 2'b10;
    @(negedge clk);
    // Centre pulses while waiting must not restart the wait
    for (int i = 0; i < 200 && rx_stop_wait === 1'b1; i++) begin
      {rx_data_centre, rx_parity_centre} = {2{i == 4}};
      if (tick16) n++;
      @(negedge clk);
      if (i == 199) begin errors++; stop_test(); end
    end
    {rx_data_centre, rx_parity_centre} = 2'h0;
    `CHK(n, 6'h10)
    `CHK({rx_stop_ok, rx_frame_err}, {b, !b})
    @(negedge clk);
    `CHK({rx_stop_ok, rx_frame_err, rx_stop_wait}, 3'h0)
  endtask
  initial begin
    repeat (6) @(negedge clk);
    nrst = 1;
    tx_run(4'h0, 2'h1, 0, 0, 6'h09);
    tx_run(4'h7, 2'h3, 0, 0, 6'h10);
    tx_run(4'h8, 2'h2, 0, 0, 6'h19);
    tx_run(4'hF, 2'h2, 0, 0, 6'h20);
    tx_run(4'h0, 2'h0, 0, 0, 6'h11);
    tx_run(4'hF, 2'h0, 0, 0, 6'h20);
    tx_run(4'h7, 2'h1, 1, 0, 6'h01);
    tx_run(4'h8, 2'h1, 1, 0, 6'h02);
    tx_run(4'h3, 2'h0, 0, 1, 6'h10);
    rx_run(0, 1);
    rx_run(1, 0);
    stop_test();
  end
endmodule
